// File: common/aas_pkg.sv
// Shared constants and types of the autoscan converter sequencer.
// Assumes a 40 MHz core clock and an 8-bit synchronous result from the analog macro.
package aas_pkg;
  // Conversion timing in core cycles
  localparam int unsigned CONV_CYCLES = 138;
  localparam int unsigned SAMPLE_CYCLES = 84;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
  localparam logic [7:0] SAMPLE_END = 8'(SAMPLE_CYCLES);
  localparam logic [2:0] LAST_CH = 3'h7;
  localparam logic [2:0] WD_CH_A = 3'h6;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DATA0 = 6'h00;
  localparam logic [5:0] IDX_LT6 = 6'h08;
  localparam logic [5:0] IDX_LT7 = 6'h09;
  localparam logic [5:0] IDX_UT6 = 6'h0a;
  localparam logic [5:0] IDX_UT7 = 6'h0b;
  localparam logic [5:0] IDX_CRR = 6'h0c;
  localparam logic [5:0] IDX_CLR = 6'h0d;
  localparam logic [5:0] IDX_ICR = 6'h0e;
  // Control logic register fields
  localparam int unsigned CLR_RUN = 0;
  localparam int unsigned CLR_CONT = 1;
  localparam int unsigned CLR_BIAS = 2;
  localparam int unsigned CLR_TMR_EN = 3;
  localparam int unsigned CLR_PIN_EN = 4;
  localparam int unsigned CLR_FIRST = 5;
  localparam logic [7:0] CLR_RESET = 8'h00;
  // Interrupt control register fields
  localparam int unsigned ICR_WD_EN = 4;
  localparam int unsigned ICR_EOS_EN = 5;
  localparam int unsigned ICR_WD_PEND = 6;
  localparam int unsigned ICR_EOS_PEND = 7;
  localparam logic [7:0] ICR_RESET = 8'h00;
  // Compare flags, kept as the upper nibble
  localparam int unsigned CRR_C6L = 0;
  localparam int unsigned CRR_C7L = 1;
  localparam int unsigned CRR_C6U = 2;
  localparam int unsigned CRR_C7U = 3;
  localparam logic [3:0] CRR_LOW_ONES = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {SEQ_IDLE, SEQ_CONVERT} aas_seq_t;

  typedef struct packed {
    logic [2:0] channel;
    logic sample;
    logic convert;
    logic biasEn;
  } aas_ana_t;
endpackage

// File: logic/aas_sequencer.sv
// Autoscan sequencer of an eight-channel 8-bit converter with AXI4-Lite registers.
// Assumes the analog macro presents a settled result on the last conversion cycle.
// Function
// (RL1) Conversion 138 cycles, first 84 sampling.
// (RL2) Continuous bit one, otherwise single mode.
// (RL3) Start at first channel, step to 7.
// (RL4) While running, convert and store per channel.
// (RL5) Single: clear run after 7, raise end.
// (RL6) Continuous: restart at first channel after 7.
// (RL7) End request whenever channel 7 finishes.
// (RL8) New result overwrites the data register.
// (RL9) Two triggers gated separately then ORed.
// (RL10) Accepted trigger sets the run bit.
// (RL11) Continuous mode ignores later trigger pulses.
// (RL12) Trigger while run set is ignored.
// (RL13) Triggers low one cycle, spaced apart.
// (RL14) Software enables only one trigger source.
// (RL15) Channels 6/7 out of window flag watchdog.
// (RL16) Compare register low nibble reads ones.
// (RL17) Flags cleared by reset or pending clear.
// (RL18) Bias on 60 us before first start.
// (RL19) Bias bit zero at reset and halt.
// (RL20) Watchdog pending is interrupt control bit 6.
// (RL21) Watchdog request served before end request.
// (RL22) Software clears pending; setting raises request.
// (RL23) Control write aborts and restarts scanning.
// (RL24) Compare bits 7..4: 7U,6U,7L,6L.
// (RL25) First channel in control bits 7..5.
// (RL26) Unconverted channels keep their data.
`timescale 1ns/1ps
`default_nettype none
module aas_sequencer
  import aas_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Triggers and system state
  input wire logic pinTriggerInput,
  input wire logic timerEventTrigger,
  input wire logic haltReq,
  // Analog macro
  input wire logic [7:0] anaResult,
  output aas_ana_t anaCtl,
  // Interrupt requests
  output logic irqReq,
  output logic irqSrcWatchdog,
  output logic endOfSequenceIrq,
  output logic watchdogIrq
);
  logic pinSync1_q, pinSync2_q, pinPrev_q;
  logic timerPrev_q;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [5:0] awIdx_q, awIdx_d;
  logic [7:0] wByte_q, wByte_d;
  logic wLane_q, wLane_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic [7:0] data_q [8];
  logic [7:0] data_d [8];
  logic [7:0] lt6_q, lt6_d, lt7_q, lt7_d, ut6_q, ut6_d, ut7_q, ut7_d;
  logic [3:0] crr_q, crr_d;
  logic [7:0] ctrl_q, ctrl_d, icr_q, icr_d;
  aas_seq_t seq_q, seq_d;
  logic [2:0] ch_q, ch_d;
  logic [7:0] cnt_q, cnt_d;
  logic doWrite, wrEn, ctrlWr, icrWr, trigEvent, trigAccept, endConv;
  logic [3:0] cmpHit;
  logic [5:0] arIdx;

  function automatic logic idxMapped(input logic [5:0] idx);
    return idx <= IDX_ICR;
  endfunction

  function automatic logic [7:0] readReg(input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx < IDX_LT6) begin
      v = data_q[idx[2:0]];
    end else begin
      unique case (idx)
        IDX_LT6: v = lt6_q;
        IDX_LT7: v = lt7_q;
        IDX_UT6: v = ut6_q;
        IDX_UT7: v = ut7_q;
        IDX_CRR: v = {crr_q, CRR_LOW_ONES}; // see (RL16) (RL24)
        IDX_CLR: v = ctrl_q;
        IDX_ICR: v = icr_q;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // Pin trigger crosses in from outside; timer event is on this clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinSync1_q <= 1'b1;
      pinSync2_q <= 1'b1;
      pinPrev_q <= 1'b1;
      timerPrev_q <= 1'b0;
    end else begin
      pinSync1_q <= pinTriggerInput;
      pinSync2_q <= pinSync1_q;
      pinPrev_q <= pinSync2_q;
      timerPrev_q <= timerEventTrigger;
    end
  end

  // Falling pin edge, rising timer edge, each behind its own enable
  assign trigEvent = (ctrl_q[CLR_PIN_EN] && pinPrev_q && !pinSync2_q)
                   || (ctrl_q[CLR_TMR_EN] && timerEventTrigger && !timerPrev_q); // see (RL9)
  // Run bit set covers both busy and continuous flow
  assign trigAccept = trigEvent && !ctrl_q[CLR_RUN] && !ctrlWr; // see (RL11) (RL12)

  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrEn = doWrite && wLane_q && idxMapped(awIdx_q);
  assign ctrlWr = wrEn && (awIdx_q == IDX_CLR);
  assign icrWr = wrEn && (awIdx_q == IDX_ICR);
  assign endConv = (seq_q == SEQ_CONVERT) && (cnt_q == CONV_LAST);
  assign arIdx = s_axi_araddr[7:2];

  always_comb begin
    cmpHit = 4'h0;
    if (endConv && ch_q == WD_CH_A) begin
      cmpHit[CRR_C6U] = anaResult >= ut6_q; // see (RL15)
      cmpHit[CRR_C6L] = anaResult < lt6_q;
    end
    if (endConv && ch_q == LAST_CH) begin
      cmpHit[CRR_C7U] = anaResult >= ut7_q;
      cmpHit[CRR_C7L] = anaResult < lt7_q;
    end
  end

  // Bus slave: address and data taken in either order
  always_comb begin
    awHeld_d = awHeld_q;
    awIdx_d = awIdx_q;
    wHeld_d = wHeld_q;
    wByte_d = wByte_q;
    wLane_d = wLane_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    if (s_axi_awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awIdx_d = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && !wHeld_q) begin
      wHeld_d = 1'b1;
      wByte_d = s_axi_wdata[7:0];
      wLane_d = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = idxMapped(awIdx_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (s_axi_arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rResp_d = idxMapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
      rData_d = {24'h000000, readReg(arIdx)};
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  // Register file and sequencer
  always_comb begin
    data_d = data_q;
    lt6_d = lt6_q;
    lt7_d = lt7_q;
    ut6_d = ut6_q;
    ut7_d = ut7_q;
    crr_d = crr_q;
    ctrl_d = ctrl_q;
    icr_d = icr_q;
    seq_d = seq_q;
    ch_d = ch_q;
    cnt_d = cnt_q;
    if (wrEn) begin
      if (awIdx_q < IDX_LT6) begin
        data_d[awIdx_q[2:0]] = wByte_q;
      end
      unique case (awIdx_q)
        IDX_LT6: lt6_d = wByte_q;
        IDX_LT7: lt7_d = wByte_q;
        IDX_UT6: ut6_d = wByte_q;
        IDX_UT7: ut7_d = wByte_q;
        IDX_CRR: crr_d = crr_q & wByte_q[7:4];
        IDX_CLR: ctrl_d = wByte_q;
        IDX_ICR: icr_d = wByte_q; // see (RL22)
        default: ;
      endcase
    end
    // Pending clear also drops the compare flags
    if (icrWr && icr_q[ICR_WD_PEND] && !wByte_q[ICR_WD_PEND]) begin
      crr_d = 4'h0; // see (RL17)
    end
    if (trigAccept) begin
      ctrl_d[CLR_RUN] = 1'b1; // see (RL10)
    end
    if (ctrlWr) begin
      // Any control write aborts the scan; it restarts from the first channel only if the written run and bias bits are set
      seq_d = SEQ_IDLE; // see (RL23)
      cnt_d = 8'h00;
    end else begin
      unique case (seq_q)
        SEQ_IDLE: begin
          // Bias off disables the converter entirely
          if (ctrl_q[CLR_RUN] && ctrl_q[CLR_BIAS]) begin
            seq_d = SEQ_CONVERT; // see (RL4)
            ch_d = ctrl_q[CLR_FIRST +: 3]; // see (RL3) (RL25)
            cnt_d = 8'h00;
          end
        end
        SEQ_CONVERT: begin
          if (!ctrl_q[CLR_RUN] || !ctrl_q[CLR_BIAS]) begin
            seq_d = SEQ_IDLE;
            cnt_d = 8'h00;
          end else if (endConv) begin
            // Only the converted channel is touched
            data_d[ch_q] = anaResult; // see (RL8) (RL26)
            cnt_d = 8'h00;
            if (ch_q == LAST_CH) begin
              icr_d[ICR_EOS_PEND] = 1'b1; // see (RL7)
              ch_d = ctrl_q[CLR_FIRST +: 3]; // see (RL6)
              if (!ctrl_q[CLR_CONT]) begin
                ctrl_d[CLR_RUN] = 1'b0; // see (RL2) (RL5)
                seq_d = SEQ_IDLE;
              end
            end else begin
              ch_d = ch_q + 3'h1; // see (RL3)
            end
          end else begin
            cnt_d = cnt_q + 8'h01; // see (RL1)
          end
        end
      endcase
    end
    // Hardware sets win over a clear in the same cycle
    crr_d = crr_d | cmpHit;
    if (cmpHit != 4'h0) begin
      icr_d[ICR_WD_PEND] = 1'b1; // see (RL20)
    end
    if (haltReq) begin
      ctrl_d[CLR_BIAS] = 1'b0; // see (RL19)
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awHeld_q <= 1'b0;
      awIdx_q <= 6'h00;
      wHeld_q <= 1'b0;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q <= RESP_OKAY;
      rData_q <= 32'h00000000;
    end else begin
      awHeld_q <= awHeld_d;
      awIdx_q <= awIdx_d;
      wHeld_q <= wHeld_d;
      wByte_q <= wByte_d;
      wLane_q <= wLane_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= 8'h00;
      end
      lt6_q <= 8'h00;
      lt7_q <= 8'h00;
      ut6_q <= 8'h00;
      ut7_q <= 8'h00;
      crr_q <= 4'h0; // see (RL17)
      ctrl_q <= CLR_RESET; // see (RL19)
      icr_q <= ICR_RESET;
      seq_q <= SEQ_IDLE;
      ch_q <= 3'h0;
      cnt_q <= 8'h00;
    end else begin
      data_q <= data_d;
      lt6_q <= lt6_d;
      lt7_q <= lt7_d;
      ut6_q <= ut6_d;
      ut7_q <= ut7_d;
      crr_q <= crr_d;
      ctrl_q <= ctrl_d;
      icr_q <= icr_d;
      seq_q <= seq_d;
      ch_q <= ch_d;
      cnt_q <= cnt_d;
    end
  end

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  assign anaCtl = '{
    channel: ch_q,
    sample: (seq_q == SEQ_CONVERT) && (cnt_q < SAMPLE_END), // see (RL1)
    convert: seq_q == SEQ_CONVERT,
    biasEn: ctrl_q[CLR_BIAS]
  };

  assign watchdogIrq = icr_q[ICR_WD_PEND] && icr_q[ICR_WD_EN];
  assign endOfSequenceIrq = icr_q[ICR_EOS_PEND] && icr_q[ICR_EOS_EN];
  assign irqReq = watchdogIrq || endOfSequenceIrq;
  // Watchdog wins; end request stays pending
  assign irqSrcWatchdog = watchdogIrq; // see (RL21)

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_conv_length: assert property (endConv |-> $past(cnt_q, 137) == 8'h00) // see (RL1)
    else $error("conversion not 138 cycles");
  a_sample_window: assert property (anaCtl.sample |-> cnt_q < SAMPLE_END && anaCtl.convert) // see (RL1)
    else $error("sampling outside first 84 cycles");
  a_single_stop: assert property (endConv && ch_q == 3'h7 && !ctrl_q[1] && ctrl_q[2] && !ctrlWr
    && !trigAccept |=> !ctrl_q[0] && seq_q == SEQ_IDLE) // see (RL5)
    else $error("single mode did not stop after channel 7");
  a_cont_restart: assert property (endConv && ch_q == 3'h7 && ctrl_q[1] && ctrl_q[2] && !ctrlWr
    |=> seq_q == SEQ_CONVERT && ch_q == $past(ctrl_q[7:5]) ##1 cnt_q == 8'd1) // see (RL6)
    else $error("continuous mode did not restart");
  a_eos_pending: assert property (endConv && ch_q == 3'h7 && ctrl_q[2] && !ctrlWr |=> icr_q[7]) // see (RL7)
    else $error("end of sequence not flagged");
  a_data_store: assert property (endConv && ctrl_q[0] && ctrl_q[2] && !ctrlWr
    |=> data_q[$past(ch_q)] == $past(anaResult)) // see (RL8)
    else $error("result not stored");
  a_ch_step: assert property (endConv && ch_q != 3'h7 && ctrl_q[0] && ctrl_q[2] && !ctrlWr
    |=> ch_q == $past(ch_q) + 3'h1) // see (RL3)
    else $error("channel did not advance");
  a_trig_start: assert property (trigAccept && !haltReq |=> ctrl_q[0] ##1 seq_q == SEQ_CONVERT
    || !ctrl_q[2]) // see (RL10)
    else $error("trigger did not start");
  a_trig_ignore: assert property (trigEvent && ctrl_q[0] && !ctrlWr && !endConv
    |=> ctrl_q[0]) // see (RL12)
    else $error("busy trigger disturbed run");
  a_abort_write: assert property (ctrlWr |=> seq_q == SEQ_IDLE && cnt_q == 8'h00) // see (RL23)
    else $error("control write did not abort");
  a_wd_flag: assert property (cmpHit != 4'h0 |=> icr_q[6] && (crr_q & $past(cmpHit)) ==
    $past(cmpHit)) // see (RL15)
    else $error("watchdog flag missing");
  a_bias_halt: assert property (haltReq |=> !ctrl_q[2]) // see (RL19)
    else $error("bias kept on in halt");
  // End request must survive being outranked
  a_irq_prio: assert property (watchdogIrq && endOfSequenceIrq && !icrWr
    |-> irqSrcWatchdog && irqReq ##1 icr_q[ICR_EOS_PEND]) // see (RL21)
    else $error("priority wrong");

  c_cont_wrap: cover property (endConv && ch_q == 3'h7 && ctrl_q[1]);
  c_single_end: cover property (endConv && ch_q == 3'h7 && !ctrl_q[1]);
  c_trig_start: cover property (trigAccept);
  c_wd_hit: cover property (cmpHit != 4'h0);
endmodule // aas_sequencer
`default_nettype wire

// File: dv/aas_far_model.sv
// Far-side model: analog input mux and the two trigger sources.
// Assumes the bench raises a fire request for one cycle after an edge.
`timescale 1ns/1ps
`default_nettype none
module aas_far_model
  import aas_pkg::*;
(
  // Clock
  input wire logic clock,
  // Bench requests
  input wire logic [63:0] levels,
  input wire logic firePin,
  input wire logic fireTmr,
  // Device side
  input wire aas_ana_t anaCtl,
  output logic [7:0] anaResult,
  output logic pinTriggerInput,
  output logic timerEventTrigger
);
  logic [1:0] lowCnt = 2'h0;
  initial begin
    anaResult = 8'h00;
    pinTriggerInput = 1'b1;
    timerEventTrigger = 1'b0;
  end
  always @(posedge clock) begin
    // Unbiased mux floats: toggle so no stale value passes
    anaResult <= anaCtl.biasEn ? levels[{anaCtl.channel, 3'b000} +: 8] : ~anaResult;
    timerEventTrigger <= fireTmr;
    // Pin low three cycles, above the one-cycle minimum
    lowCnt <= firePin ? 2'h2 : lowCnt - {1'b0, lowCnt != 2'h0};
    pinTriggerInput <= !(firePin || lowCnt != 2'h0);
  end
endmodule // aas_far_model
`default_nettype wire

// File: dv/test_adc_autoscan_sequencer.sv
// Self-checking bench of the autoscan sequencer.
// Assumes the package and the far-side model compile first.
`timescale 1ns/1ps
`default_nettype none
module test_adc_autoscan_sequencer
  import aas_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic firePin = 1'b0, fireTmr = 1'b0, haltReq = 1'b0, prevS = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pinTrg, tmrTrg, irqReq, irqSrcWd, eosIrq, wdIrq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, anaResult;
  logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'hf33a;
  logic [1:0] bresp, rresp, rsp;
  logic [63:0] levels = 64'h0;
  aas_ana_t anaCtl;
  int err_count = 0, samples_checked = 0, cyc = 0, gap = 999, smp = 0;
  int expData[8];

  always #12.5 clock = ~clock;

  aas_sequencer dut (.clock(clock), .nrst(nrst), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pinTriggerInput(pinTrg), .timerEventTrigger(tmrTrg), .haltReq(haltReq),
    .anaResult(anaResult), .anaCtl(anaCtl), .irqReq(irqReq), .irqSrcWatchdog(irqSrcWd),
    .endOfSequenceIrq(eosIrq), .watchdogIrq(wdIrq));
  aas_far_model far (.clock(clock), .levels(levels), .firePin(firePin), .fireTmr(fireTmr),
    .anaCtl(anaCtl), .anaResult(anaResult), .pinTriggerInput(pinTrg),
    .timerEventTrigger(tmrTrg));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [5:0] idx, input logic [7:0] d);
    @(posedge clock);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    if (idx == IDX_CLR) gap = 999;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask

  task automatic axr(input logic [5:0] idx);
    @(posedge clock);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata;
    rsp = rresp;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Window 40..bf on both guarded channels
  function automatic logic [31:0] crrExp();
    return {24'h0, levels[63:56] >= 8'hc0, levels[55:48] >= 8'hc0,
      levels[63:56] < 8'h40, levels[55:48] < 8'h40, 4'hf};
  endfunction

  task automatic setLv(input logic [7:0] c6, input logic [7:0] c7);
    seed = lfsr(seed);
    levels <= {c7, c6, seed[15:0], lfsr(seed)};
  endtask

  task automatic cmpData(input int first);
    for (int c = first; c < 8; c++) expData[c] = levels[8*c +: 8];
    for (int c = 0; c < 8; c++) begin
      axr(c[5:0]);
      chk(rv, expData[c]);
    end
  endtask

  task automatic pulse(input logic pin);
    @(posedge clock);
    if (pin) firePin <= 1'b1;
    else fireTmr <= 1'b1;
    @(posedge clock);
    firePin <= 1'b0;
    fireTmr <= 1'b0;
  endtask

  always @(posedge clock) begin
    cyc++;
    gap++;
    if (anaCtl.sample === 1'b1) smp++;
    // Starts within one run lie one conversion apart
    if (anaCtl.sample === 1'b1 && prevS !== 1'b1) begin
      if (gap < 300) chk(32'(gap), 32'(CONV_CYCLES));
      gap = 0;
    end
    prevS = anaCtl.sample;
    if (cyc > 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    chk({26'h0, anaCtl}, 32'h0);
    axr(IDX_CRR);
    chk(rv, 32'h0f);
    axr(IDX_CLR);
    chk(rv, 32'h00);
    axw(6'h0f, 8'hff);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axr(6'h0f);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk(rv, 32'h00);
    $display("reset test done");
    // Preload data so untouched channels show
    for (int c = 0; c < 12; c++) begin
      axw(c[5:0], c < 8 ? 8'ha0 + c[7:0] : (c < 10 ? 8'h40 : 8'hc0));
      if (c < 8) expData[c] = 'ha0 + c;
    end
    axw(IDX_ICR, 8'h30);
    setLv(8'hc0, 8'h3f);
    // Bias settles 60 us (2400 cycles) before the first start
    axw(IDX_CLR, 8'ha4);
    repeat (2410) @(posedge clock);
    smp = 0;
    axw(IDX_CLR, 8'ha5);
    do axr(IDX_CLR); while (rv[0] !== 1'b0);
    chk(rv, 32'ha4);
    chk(32'(smp), 32'(3 * SAMPLE_CYCLES));
    cmpData(5);
    axr(IDX_CRR);
    chk(rv, crrExp());
    axr(IDX_ICR);
    chk(rv, 32'hf0);
    chk({28'h0, irqSrcWd, wdIrq, eosIrq, irqReq}, 32'hf);
    axw(IDX_ICR, 8'hb0);
    axr(IDX_CRR);
    chk(rv, 32'h0f);
    chk({30'h0, irqSrcWd, irqReq}, 32'h1);
    axw(IDX_ICR, 8'h30);
    chk({31'h0, irqReq}, 32'h0);
    axw(IDX_ICR, 8'h70);
    chk({30'h0, irqSrcWd, irqReq}, 32'h3);
    $display("single test done");
    axw(IDX_CLR, 8'hf4);
    pulse(1'b0);
    repeat (20) @(posedge clock);
    axr(IDX_CLR);
    chk(rv, 32'hf4);
    axw(IDX_ICR, 8'h30);
    setLv(8'h80, 8'h55);
    // Single-mode starts must lie further apart than one group
    for (int n = 0; n < 2; n++) begin
      repeat (300) @(posedge clock);
      pulse(1'b1);
      do axr(IDX_CLR); while (rv[0] !== 1'b1);
      do axr(IDX_CLR); while (rv[0] !== 1'b0);
    end
    repeat (300) @(posedge clock);
    axr(IDX_CLR);
    chk(rv, 32'hf4);
    cmpData(7);
    axr(IDX_ICR);
    chk(rv, 32'hb0);
    $display("trigger test done");
    axw(IDX_ICR, 8'h30);
    setLv(8'h10, 8'hf0);
    axw(IDX_CLR, 8'hce);
    pulse(1'b0);
    do axr(IDX_ICR); while (rv[7] !== 1'b1);
    axw(IDX_ICR, 8'h30);
    pulse(1'b0);
    do axr(IDX_ICR); while (rv[7] !== 1'b1);
    axr(IDX_CLR);
    chk(rv, 32'hcf);
    cmpData(6);
    axr(IDX_CRR);
    chk(rv, crrExp());
    do @(posedge clock); while (anaCtl.channel !== LAST_CH);
    axw(IDX_CLR, 8'hcf);
    repeat (3) @(posedge clock);
    chk({28'h0, anaCtl.convert, anaCtl.channel}, 32'he);
    @(posedge clock);
    haltReq <= 1'b1;
    @(posedge clock);
    haltReq <= 1'b0;
    axr(IDX_CLR);
    chk(rv, 32'hcb);
    chk({31'h0, anaCtl.convert}, 32'h0);
    axw(IDX_CLR, 8'h00);
    $display("continuous test done");
    give_verdict();
  end
endmodule // test_adc_autoscan_sequencer
`default_nettype wire
